//--- core/tsc_ctrl.sv
// serial control port of the tuner synthesiser, device side
`timescale 1ns/10ps
`default_nettype none
// Operation
// RULE1: all programming arrives over the two-wire bus, data on sda, clock on scl.
// RULE2: a transfer is either write (control data in) or read (status out).
// RULE3: address lsb high selects read mode, low selects write mode.
// RULE4: a matching address byte is acknowledged by holding sda low.
// RULE5: in write mode every further data byte is acknowledged too.
// RULE6: master acks a status byte low to get another one.
// RULE7: programmable address bits come from the address select pin level.
// RULE8: one fixed address always answered plus one of three programmable.
// RULE9: pump current select bit: clear is low current, set is high current.
// RULE10: pump disable bit 4 of the control byte turns the pump off.
// RULE11: six open-collector ports hold their programmed state.
// RULE12: port logic levels are readable in the status byte.
// RULE13: analog level input gives a three-bit code in the status byte.
// RULE14: address byte msb first: 11000, two programmable bits, read/write bit.
// RULE15: pin low gives 00, middle 10, high 11; 01 always valid.
// RULE16: write byte starting 0 is divider data, starting 1 is control; code needs bits 3..1 set for control, else port data.
// RULE17: status order: power-on flag, lock flag, three port inputs, analog code.
// RULE18: unmatched address leaves sda released for the rest of the transfer.
module tsc_ctrl (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [1:0] address_select_port,
  input wire logic [2:0] analog_level_input_port,
  input wire logic [2:0] port_in,
  input wire logic phase_lock_flag,
  output logic [14:0] divider_ratio,
  output logic pump_current_select,
  output logic pump_disable,
  output logic drive_off,
  output logic test_mode,
  output logic [3:0] low_output_ports,
  output logic output_port_six,
  output logic output_port_seven
);
  import tsc_pkg::*;

  // ==================== pin synchronisers
  logic [7:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic [1:0] lvl_s;
  logic [2:0] adc_s;
  logic [2:0] pin_s;
  logic lock_s;
  tsc_sync #(.W(8)) u_sync_pins (
    .clk(clk),
    .sys_rst(sys_rst),
    .d({address_select_port, analog_level_input_port, port_in}),
    .q(pins_s)
  );
  // bus levels pass inverted so the cleared stages read as an idle-high bus, no false edge
  logic scl_sn;
  logic sda_sn;
  tsc_sync #(.W(3)) u_sync_bus (
    .clk(clk),
    .sys_rst(sys_rst),
    .d({~scl_in, ~sda_in, phase_lock_flag}),
    .q({scl_sn, sda_sn, lock_s})
  );
  assign scl_s = ~scl_sn;
  assign sda_s = ~sda_sn;
  assign lvl_s = pins_s[7:6];
  assign adc_s = pins_s[5:3];
  assign pin_s = pins_s[2:0];

  // ==================== bus condition detection
  logic scl_d;
  logic sda_d;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  assign scl_rise = scl_s & ~scl_d; // RULE1
  assign scl_fall = ~scl_s & scl_d;
  assign start_c = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_c = scl_s & scl_d & ~sda_d & sda_s;

  // ==================== programmable address from pin level
  logic [1:0] prog_addr;
  always_comb begin
    unique case (lvl_s) // RULE7 RULE15
      LVL_LOW: prog_addr = SEL_LOW;
      LVL_MID: prog_addr = SEL_MID;
      LVL_HIGH: prog_addr = SEL_HIGH;
      default: prog_addr = ADDR_ALWAYS; // unresolved level: only the fixed code answers
    endcase
  end

  // ==================== byte engine
  tsc_state_t state;
  logic bit_seen;
  logic [7:0] shreg;
  logic [2:0] bitcnt;
  logic read_mode;
  logic addr_phase;
  logic addr_ok;
  logic [6:0] div_hi;
  logic div_hi_ok;
  logic por_flag;
  logic por_clear;
  logic [7:0] status;
  assign status = {por_flag, lock_s, pin_s, adc_s}; // RULE12 RULE13 RULE17
  assign addr_ok = (shreg[7:3] == ADDR_FIXED_BITS) &&
                   ((shreg[2:1] == ADDR_ALWAYS) || (shreg[2:1] == prog_addr)); // RULE8 RULE14

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= TSC_IDLE;
      bit_seen <= 1'b0;
      shreg <= 8'h00;
      bitcnt <= 3'h0;
      read_mode <= 1'b0;
      addr_phase <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
    end else if (start_c) begin
      state <= TSC_ADDR;
      bitcnt <= 3'h0;
      bit_seen <= 1'b0;
      addr_phase <= 1'b1;
      sda_oe <= 1'b0;
    end else if (stop_c) begin
      state <= TSC_IDLE;
      sda_oe <= 1'b0;
    end else begin
      unique case (state)
        TSC_IDLE: sda_oe <= 1'b0; // RULE18
        TSC_ADDR, TSC_WDATA: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], sda_s};
            bitcnt <= bitcnt + 3'h1;
            bit_seen <= 1'b1;
          end
          // the fall closing a start also sees a zero count; only a full byte counts
          if (scl_fall && bitcnt == 3'h0 && bit_seen) begin
            bit_seen <= 1'b0;
            if (state == TSC_ADDR && !addr_ok) begin
              state <= TSC_IDLE; // RULE18
            end else begin
              sda_out <= 1'b0;
              sda_oe <= 1'b1; // RULE4 RULE5
              read_mode <= (state == TSC_ADDR) ? shreg[0] : read_mode; // RULE3
              state <= TSC_ACK;
            end
          end
        end
        TSC_ACK: begin
          if (scl_fall) begin
            addr_phase <= 1'b0;
            if (read_mode) begin
              state <= TSC_RDATA; // RULE2
              sda_out <= status[7];
              sda_oe <= ~status[7];
              shreg <= {status[6:0], 1'b1};
              bitcnt <= 3'h0;
            end else begin
              state <= TSC_WDATA; // RULE2
              sda_oe <= 1'b0;
            end
          end
        end
        TSC_RDATA: begin
          if (scl_fall) begin
            if (bitcnt == BIT_LAST) begin
              sda_oe <= 1'b0;
              state <= TSC_MACK;
            end else begin
              sda_out <= shreg[7];
              sda_oe <= ~shreg[7];
              shreg <= {shreg[6:0], 1'b1};
            end
            bitcnt <= bitcnt + 3'h1;
          end
        end
        TSC_MACK: begin
          if (scl_rise) begin
            state <= sda_s ? TSC_IDLE : TSC_ACK; // RULE6
          end
        end
      endcase
    end
  end

  // ==================== power-on flag, cleared by stop ending a read
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      por_flag <= 1'b1;
      por_clear <= 1'b0;
    end else begin
      if (start_c) begin
        por_clear <= 1'b0;
      end else if (state == TSC_RDATA) begin
        por_clear <= 1'b1;
      end
      if (stop_c && por_clear) begin
        por_flag <= 1'b0;
      end
    end
  end

  // ==================== write data decode, a byte is used only when complete
  logic byte_done;
  assign byte_done = (state == TSC_WDATA) && scl_fall && bitcnt == 3'h0 && !addr_phase;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      divider_ratio <= DIV_RESET;
      div_hi <= 7'h00;
      div_hi_ok <= 1'b0;
      pump_current_select <= 1'b0;
      pump_disable <= 1'b0;
      drive_off <= 1'b0;
      test_mode <= 1'b0;
      low_output_ports <= PORTS_RESET[3:0];
      output_port_six <= 1'b0;
      output_port_seven <= 1'b0;
    end else if (start_c) begin
      div_hi_ok <= 1'b0;
    end else if (byte_done) begin
      if (div_hi_ok) begin
        divider_ratio <= {div_hi, shreg}; // second divider byte
        div_hi_ok <= 1'b0;
      end else if (!shreg[BYTE_KIND_BIT]) begin
        div_hi <= shreg[6:0]; // RULE16
        div_hi_ok <= 1'b1;
      end else if (shreg[3:1] == 3'h7) begin // control byte carries fixed ones in bits 3..1
        pump_current_select <= shreg[PUMP_CUR_BIT]; // RULE9
        pump_disable <= shreg[PUMP_DIS_BIT]; // RULE10
        test_mode <= shreg[TEST_BIT];
        drive_off <= shreg[DRIVE_OFF_BIT];
      end else begin
        output_port_seven <= shreg[7]; // RULE11
        output_port_six <= shreg[6];
        low_output_ports <= shreg[3:0];
      end
    end
  end

endmodule
`default_nettype wire

//--- include/tsc_pkg.sv
// constants for the tuner synthesiser serial control port
package tsc_pkg;
  // ==================== address byte
  localparam logic [4:0] ADDR_FIXED_BITS = 5'h18;
  localparam logic [1:0] ADDR_ALWAYS = 2'h1;
  // ==================== address select voltage codes
  localparam logic [1:0] LVL_LOW = 2'h0;
  localparam logic [1:0] LVL_MID = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;
  localparam logic [1:0] SEL_LOW = 2'h0;
  localparam logic [1:0] SEL_MID = 2'h2;
  localparam logic [1:0] SEL_HIGH = 2'h3;
  // ==================== control byte fields
  localparam int BYTE_KIND_BIT = 7;
  localparam int PUMP_CUR_BIT = 6;
  localparam int TEST_BIT = 5;
  localparam int PUMP_DIS_BIT = 4;
  localparam int DRIVE_OFF_BIT = 0;
  // ==================== reset values, last read bit index and engine states
  localparam logic [14:0] DIV_RESET = 15'h0000;
  localparam logic [5:0] PORTS_RESET = 6'h00;
  localparam logic [2:0] BIT_LAST = 3'h7;
  typedef enum logic [5:0] {
    TSC_IDLE = 6'h01,
    TSC_ADDR = 6'h02,
    TSC_WDATA = 6'h04,
    TSC_RDATA = 6'h08,
    TSC_ACK = 6'h10,
    TSC_MACK = 6'h20
  } tsc_state_t;
endpackage

//--- core/tsc_sync.sv
// two flip-flop synchroniser for a group of pin levels
`timescale 1ns/10ps
`default_nettype none
module tsc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  // ==================== two stages, first read only by second
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

//--- verif/tsc_ctrl_sva.sv
// checker for the tuner synthesiser serial control port
`timescale 1ns/10ps
`default_nettype none
module tsc_ctrl_sva (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic pump_disable,
  input wire logic [14:0] divider_ratio,
  input wire logic [3:0] low_output_ports
);
  // ======== bus position
  logic pscl, psda, first, rd, wr;
  logic [3:0] cnt;
  assign wr = first || !rd;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pscl <= 1'h1;
      psda <= 1'h1;
    end else begin
      pscl <= scl_in;
      psda <= sda_in;
    end
  end
  // cnt counts scl falls after a start; 8 marks the ack slot
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt <= 4'hF;
      first <= 1'h0;
      rd <= 1'h0;
    end else if (scl_in && psda && !sda_in) begin
      cnt <= 4'hF;
      first <= 1'h1;
    end else if (pscl && !scl_in) begin
      cnt <= (cnt == 4'h8 || cnt == 4'hF) ? 4'h0 : cnt + 4'h1;
      if (cnt == 4'h8) first <= 1'h0;
    end else if (!pscl && scl_in && first && cnt == 4'h7) begin
      rd <= sda_in;
    end
  end
  // ======== properties
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_start;
    scl_in && psda && !sda_in;
  endsequence
  c_start: cover property (s_start);
  a_ack_slot: assert property ($rose(sda_oe) && wr |-> cnt == 4'h8)
    else $error("ack drive outside ack slot");
  a_ack_release: assert property ($fell(sda_oe) && wr |-> cnt == 4'h0)
    else $error("ack not released after one period");
  a_no_self_ack: assert property ($rose(sda_oe) && !wr |-> cnt != 4'h8)
    else $error("device drove master ack slot");
  a_drive_low: assert property (sda_oe |-> !sda_out)
    else $error("sda driven high");
  a_move_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("sda drive changed with scl high");
  a_hold_high: assert property ($rose(scl_in) |=> $stable(sda_oe) [*3])
    else $error("sda drive moved during scl high");
  a_quiet_reset: assert property ($fell(sys_rst) |-> !sda_oe && divider_ratio == 15'h0
    && low_output_ports == 4'h0 && !pump_disable)
    else $error("outputs not cleared by reset");
  a_read_holds: assert property (!wr |-> $stable(divider_ratio) && $stable(pump_disable))
    else $error("control changed in read mode");
  a_addr_holds: assert property (first |-> $stable(low_output_ports))
    else $error("ports changed during address byte");
endmodule
`default_nettype wire

//--- verif/tsc_master.sv
// bus controller model driving scl and sda
`timescale 1ns/10ps
`default_nettype none
module tsc_master (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  // ======== bus phases
  initial begin
    scl = 1'h1;
    sda_low = 1'h0;
  end
  // six clocks a phase keeps above the four-clock minimum
  task automatic hp;
    repeat (6) @(posedge clk);
  endtask
  task automatic start;
    sda_low <= 1'h1;
    hp;
    scl <= 1'h0;
    hp;
  endtask
  task automatic stop;
    sda_low <= 1'h1;
    hp;
    scl <= 1'h1;
    hp;
    sda_low <= 1'h0;
    hp;
  endtask
  // nine bits msb first; bit 0 is the ack slot
  task automatic xfer(input logic [8:0] o, output logic [8:0] i);
    for (int k = 8; k >= 0; k--) begin
      sda_low <= !o[k];
      hp;
      scl <= 1'h1;
      hp;
      i[k] = sda;
      scl <= 1'h0;
    end
    hp;
  endtask
endmodule
`default_nettype wire

//--- verif/tsc_ctrl_tb.sv
// testbench for the tuner synthesiser serial control port
`timescale 1ns/10ps
`default_nettype none
module tsc_ctrl_tb;
  // ======== bench signals
  typedef struct packed {logic [1:0] s; logic [7:0] a; logic k; logic [7:0] c;} tsc_row_t;
  logic clk, sys_rst, scl, sda_low, sda, sda_out, sda_oe, lock, pcs, pdis, doff, tm, p6, p7;
  logic [1:0] asel;
  logic [2:0] alvl, pin;
  logic [3:0] lop, e;
  logic [14:0] div;
  logic [8:0] r;
  int bad_count, num_checks;
  tsc_row_t rows [9] = '{'{2'h0, 8'hC0, 1'h1, 8'hDE}, '{2'h0, 8'hC4, 1'h0, 8'h8F},
    '{2'h1, 8'hC4, 1'h1, 8'hBF}, '{2'h1, 8'hC6, 1'h0, 8'hCE}, '{2'h2, 8'hC6, 1'h1, 8'hCE},
    '{2'h2, 8'hC2, 1'h1, 8'h8F}, '{2'h3, 8'hC2, 1'h1, 8'h9E}, '{2'h3, 8'hC0, 1'h0, 8'hFF},
    '{2'h0, 8'h80, 1'h0, 8'hDE}};
  // released sda floats high through the pull-up
  assign sda = !(sda_low || (sda_oe && !sda_out));
  tsc_master m (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  tsc_ctrl dut (.clk(clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .address_select_port(asel), .analog_level_input_port(alvl),
    .port_in(pin), .phase_lock_flag(lock), .divider_ratio(div), .pump_current_select(pcs),
    .pump_disable(pdis), .drive_off(doff), .test_mode(tm), .low_output_ports(lop),
    .output_port_six(p6), .output_port_seven(p7));
  task automatic chk(input string n, input logic [14:0] x, input logic [14:0] g);
    num_checks++;
    if (g !== x) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic send(input logic [7:0] d, input logic k);
    m.xfer({d, 1'h1}, r);
    chk("ack", 15'(!k), 15'(r[0]));
  endtask
  task automatic conclude;
    if (bad_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ======== sequence
  initial begin
    clk = 1'h0;
    forever #12.5 clk = !clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    conclude;
  end
  initial begin
    sys_rst = 1'h1;
    asel = 2'h0;
    alvl = 3'h2;
    pin = 3'h5;
    lock = 1'h1;
    e = 4'h0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'h0;
    repeat (4) @(posedge clk);
    chk("divider", 15'h0, div);
    chk("flags", 15'h0, 15'({pcs, tm, pdis, doff, p7, p6, lop}));
    foreach (rows[i]) begin
      asel <= rows[i].s;
      m.start;
      send(rows[i].a, rows[i].k);
      send(rows[i].c, rows[i].k);
      m.stop;
      if (rows[i].k) e = {rows[i].c[6], rows[i].c[5], rows[i].c[4], rows[i].c[0]};
      chk("pump flags", 15'(e), 15'({pcs, tm, pdis, doff}));
    end
    m.start;
    send(8'hC2, 1'h1);
    send(8'h5A, 1'h1);
    send(8'hC3, 1'h1);
    send(8'hC5, 1'h1);
    m.stop;
    chk("divider", 15'h5AC3, div);
    chk("ports", 15'h35, 15'({p7, p6, lop}));
    m.start;
    send(8'hC3, 1'h1);
    for (int j = 0; j < 2; j++) begin
      m.xfer({8'hFF, 1'(j)}, r);
      chk("status", 15'h0EA, 15'(r[8:1]));
    end
    m.stop;
    m.start;
    send(8'hC3, 1'h1);
    m.xfer(9'h1FF, r);
    m.stop;
    chk("status after stop", 15'h06A, 15'(r[8:1]));
    conclude;
  end
endmodule
bind tsc_ctrl tsc_ctrl_sva u_sva (.clk, .sys_rst, .scl_in, .sda_in, .sda_out, .sda_oe,
  .pump_disable, .divider_ratio, .low_output_ports);
`default_nettype wire
